// ---- rtl/whp_port.sv ----
// Wide host memory port: host pins to DMA memory requests
`timescale 1ns/1ps
`include "whp_consts.svh"

module whp_port #(
   parameter bit DUAL_PART = 1'b0,
   parameter int MEM_WORDS = `WHP_MEM_WORDS
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire whp_pkg::whp_host_in_t host_i,
   input wire logic addr_data_mux_select_i,
   input wire logic wide_port_select_i,
   output logic [`WHP_DATA_W-1:0] host_data_o,
   output logic host_data_oe_o,
   output logic host_wait_ready_o,
   output logic host_int_o,
   output whp_pkg::whp_dma_req_t dma_req_o,
   input wire whp_pkg::whp_dma_rsp_t dma_rsp_i,
   input wire logic dsp_ctl_we_i,
   input wire logic [`WHP_DATA_W-1:0] dsp_ctl_wdata_i,
   output logic [`WHP_DATA_W-1:0] dsp_ctl_o,
   output logic dsp_int_o
);
   import whp_pkg::*;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [`WHP_DATA_W-1:0] ctl_word(input whp_st_t s);
      logic [`WHP_DATA_W-1:0] w;
      w = '0;
      w[`WHP_CTL_H2D] = s.h2d;
      w[`WHP_CTL_D2H] = s.d2h;
      w[`WHP_CTL_XADR] = s.xadr;
      w[`WHP_CTL_PFEN] = s.pfen;
      return w;
   endfunction

   function automatic logic in_mem(input logic [`WHP_ADDR_W-1:0] a);
      return ({14'h0000, a} < 32'(MEM_WORDS));
   endfunction

   whp_st_t st_reg;
   whp_st_t st_next;
   logic en;
   logic mux;
   logic act;
   logic start;
   logic [`WHP_ADDR_W-1:0] acc_addr;

   // ----------------------------------------
   // Pin decode
   // ----------------------------------------
   // On a dual part, without the select the port ignores the host entirely
   assign en = !DUAL_PART || wide_port_select_i;
   // Dual parts have no mode pin, so the mode input is ignored there
   assign mux = !DUAL_PART && addr_data_mux_select_i;
   assign act = en && !st_reg.pin.cs_n && !st_reg.pin.ds_n;
   assign start = act && !st_reg.act_d;
   // Separate mode takes the address pins, else the held register
   assign acc_addr = mux ? st_reg.addr : st_reg.pin.addr;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      // One capture stage retimes the host pins to the core clock
      st_next.pin = host_i;
      // Clear first, then set, so a same-cycle event survives
      if (dsp_ctl_we_i && dsp_ctl_wdata_i[`WHP_CTL_H2D]) begin
         st_next.h2d = 1'b0;
      end
      if (dsp_ctl_we_i && dsp_ctl_wdata_i[`WHP_CTL_D2H]) begin
         st_next.d2h = 1'b1;
      end
      unique case (st_reg.st)
         ST_IDLE: begin
            st_next.act_d = act;
            if (start) begin
               st_next.rd = st_reg.pin.rw;
               st_next.st = ST_DONE;
               if (mux && st_reg.pin.sel == `WHP_SEL_CTL) begin
                  // Only reached in multiplexed mode
                  if (st_reg.pin.rw) begin
                     st_next.dout = ctl_word(st_reg);
                     st_next.doe = 1'b1;
                  end else begin
                     if (st_reg.pin.data[`WHP_CTL_D2H]) begin
                        st_next.d2h = dsp_ctl_we_i && dsp_ctl_wdata_i[`WHP_CTL_D2H];
                     end
                     if (st_reg.pin.data[`WHP_CTL_H2D]) begin
                        st_next.h2d = 1'b1;
                     end
                     st_next.xadr = st_reg.pin.data[`WHP_CTL_XADR];
                     st_next.pfen = st_reg.pin.data[`WHP_CTL_PFEN];
                  end
               end else if (mux && st_reg.pin.sel == `WHP_SEL_ADDR) begin
                  if (st_reg.pin.rw) begin
                     st_next.doe = 1'b1;
                     st_next.dout = st_reg.xadr ?
                        {14'h0000, st_reg.addr[`WHP_ADDR_W-1 -: `WHP_HI_BITS]} :
                        st_reg.addr[`WHP_DATA_W-1:0];
                  end else begin
                     // Data lines carry the address in this phase
                     if (st_reg.xadr) begin
                        st_next.addr[`WHP_ADDR_W-1 -: `WHP_HI_BITS] =
                           st_reg.pin.data[`WHP_HI_BITS-1:0];
                     end else begin
                        st_next.addr[`WHP_DATA_W-1:0] = st_reg.pin.data;
                     end
                     st_next.pf_valid = 1'b0;
                     if (st_reg.pfen) begin
                        // Prefetch hides DMA latency on the next read
                        st_next.st = ST_PREF;
                        st_next.rdy = 1'b0;
                        st_next.act_d = 1'b1;
                        st_next.dma.req = 1'b1;
                        st_next.dma.we = 1'b0;
                        st_next.dma.prio = 1'b1;
                        st_next.dma.addr = st_reg.xadr ?
                           {st_reg.pin.data[`WHP_HI_BITS-1:0],
                            st_reg.addr[`WHP_DATA_W-1:0]} :
                           {st_reg.addr[`WHP_ADDR_W-1 -: `WHP_HI_BITS],
                            st_reg.pin.data};
                     end
                  end
               end else begin
                  st_next.inc = mux && st_reg.pin.sel == `WHP_SEL_DINC;
                  if (!in_mem(acc_addr)) begin
                     // Outside memory: answered at once, reads give zero
                     st_next.dout = '0;
                     st_next.doe = st_reg.pin.rw;
                  end else if (mux && st_reg.pin.rw && st_reg.pf_valid) begin
                     st_next.dout = st_reg.pf_data;
                     st_next.doe = 1'b1;
                     st_next.pf_valid = 1'b0;
                     if (st_next.inc) begin
                        st_next.addr = st_reg.addr + 18'h00001;
                     end
                  end else begin
                     st_next.st = ST_WAIT;
                     st_next.rdy = 1'b0;
                     st_next.pf_valid = 1'b0;
                     st_next.dma.req = 1'b1;
                     st_next.dma.we = !st_reg.pin.rw;
                     st_next.dma.prio = 1'b1;
                     st_next.dma.addr = acc_addr;
                     st_next.dma.wdata = st_reg.pin.data;
                  end
               end
            end
         end
         ST_WAIT: begin
            // Host keeps its strobe low meanwhile
            if (dma_rsp_i.ack) begin
               st_next.dma.req = 1'b0;
               st_next.dma.prio = 1'b0;
               st_next.rdy = 1'b1;
               st_next.st = ST_DONE;
               if (st_reg.rd) begin
                  st_next.dout = dma_rsp_i.rdata;
                  st_next.doe = 1'b1;
               end
               if (st_reg.inc) begin
                  st_next.addr = st_reg.addr + 18'h00001;
               end
            end
         end
         ST_PREF: begin
            if (dma_rsp_i.ack) begin
               st_next.dma.req = 1'b0;
               st_next.dma.prio = 1'b0;
               st_next.pf_data = dma_rsp_i.rdata;
               st_next.pf_valid = 1'b1;
               st_next.rdy = 1'b1;
               st_next.st = ST_DONE;
            end
         end
         ST_DONE: begin
            // Bus is released only once the strobe goes away
            if (!act) begin
               st_next.doe = 1'b0;
               st_next.act_d = 1'b0;
               st_next.st = ST_IDLE;
            end
         end
      endcase
      if (!en) begin
         st_next.doe = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= '{st: ST_IDLE, pin: '{cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1,
                     sel: 2'h0, addr: '0, data: '0},
                     rdy: 1'b1, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign host_data_o = st_reg.dout;
   assign host_data_oe_o = st_reg.doe;
   assign host_wait_ready_o = st_reg.rdy;
   assign host_int_o = st_reg.d2h;
   assign dsp_int_o = st_reg.h2d;
   assign dma_req_o = st_reg.dma;
   assign dsp_ctl_o = ctl_word(st_reg);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_ack_seen;
      st_reg.st == ST_WAIT && dma_rsp_i.ack;
   endsequence

   sequence s_ready_back;
      host_wait_ready_o && dma_req_o.req == 1'b0;
   endsequence

   property p_ready_after_ack;
      @(posedge mclk_i) disable iff (!resetn_i)
      s_ack_seen |=> s_ready_back;
   endproperty

   a_ready_after_ack: assert property (p_ready_after_ack)
      else $error("ready not restored after dma ack");

   a_ready_low_wait: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      dma_req_o.req |-> !host_wait_ready_o)
      else $error("ready high while dma pending");

   a_req_held: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      dma_req_o.req && !dma_rsp_i.ack |=> dma_req_o.req && $stable(dma_req_o.addr))
      else $error("dma request dropped before ack");

   a_prio_host: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      dma_req_o.req |-> dma_req_o.prio)
      else $error("host request without priority");

   a_ctl_sep_mode: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st_reg.st == ST_IDLE && start && !mux && st_reg.pin.rw && in_mem(acc_addr)
      |=> dma_req_o.req && dma_req_o.addr == $past(st_reg.pin.addr))
      else $error("separate mode read not sent to memory");

   a_autoinc_step: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st_reg.st == ST_WAIT && dma_rsp_i.ack && st_reg.inc
      |=> st_reg.addr == $past(st_reg.addr) + 18'h00001)
      else $error("address did not step by one");

   a_disabled_quiet: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !en |=> !host_data_oe_o)
      else $error("disabled port drives data");

   a_set_wins: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st_reg.st == ST_IDLE && start && mux && st_reg.pin.sel == `WHP_SEL_CTL
      && !st_reg.pin.rw && st_reg.pin.data[`WHP_CTL_H2D] |=> dsp_int_o)
      else $error("host interrupt request lost");

   a_oe_read_only: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      host_data_oe_o |-> st_reg.rd)
      else $error("data driven during host write");

endmodule // whp_port

// ---- rtl/whp_consts.svh ----
// Constants of the wide host memory port
`ifndef WHP_CONSTS_SVH
`define WHP_CONSTS_SVH
`define WHP_ADDR_W 18
`define WHP_DATA_W 16
`define WHP_MEM_WORDS 262144
`define WHP_CTL_H2D 0
`define WHP_CTL_D2H 1
`define WHP_CTL_XADR 2
`define WHP_CTL_PFEN 3
`define WHP_SEL_CTL 2'h0
`define WHP_SEL_DINC 2'h1
`define WHP_SEL_ADDR 2'h2
`define WHP_SEL_DATA 2'h3
`define WHP_HI_BITS 2
`endif

// ---- rtl/whp_pkg.sv ----
// Types of the wide host memory port
`include "whp_consts.svh"
package whp_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PREF, ST_DONE} whp_state_t;
   typedef struct packed {
      logic cs_n;
      logic ds_n;
      logic rw;
      logic [1:0] sel;
      logic [`WHP_ADDR_W-1:0] addr;
      logic [`WHP_DATA_W-1:0] data;
   } whp_host_in_t;
   typedef struct packed {
      logic req;
      logic we;
      logic prio;
      logic [`WHP_ADDR_W-1:0] addr;
      logic [`WHP_DATA_W-1:0] wdata;
   } whp_dma_req_t;
   typedef struct packed {
      logic ack;
      logic [`WHP_DATA_W-1:0] rdata;
   } whp_dma_rsp_t;
   typedef struct packed {
      whp_state_t st;
      whp_host_in_t pin;
      logic act_d;
      logic rd;
      logic inc;
      logic [`WHP_ADDR_W-1:0] addr;
      logic h2d;
      logic d2h;
      logic xadr;
      logic pfen;
      logic pf_valid;
      logic [`WHP_DATA_W-1:0] pf_data;
      logic rdy;
      logic doe;
      logic [`WHP_DATA_W-1:0] dout;
      whp_dma_req_t dma;
   } whp_st_t;
endpackage

// ---- verif/whp_host_model.sv ----
// Host processor model driving the wide host memory port pins
`timescale 1ns/1ps
module whp_host_model (
   input wire logic mclk_i,
   input wire logic ready_i,
   input wire logic oe_i,
   input wire logic [15:0] data_i,
   output whp_pkg::whp_host_in_t host_o
);
   import whp_pkg::*;
   logic [15:0] last;
   initial begin
      host_o = '{cs_n: 1'b1, ds_n: 1'b1, default: '0};
      last = 16'h0;
   end
   // Released bus shows the inverse of its last value
   task automatic xfer(input logic rw, input logic [1:0] sel, input logic [17:0] a,
      input logic [15:0] wd, output logic [15:0] rd, output logic oe, output logic waited);
      int n;
      waited = 1'b0;
      @(negedge mclk_i);
      if (!rw) last = wd;
      host_o = '{cs_n: 1'b0, ds_n: 1'b0, rw: rw, sel: sel, addr: a, data: rw ? ~last : wd};
      repeat (2) @(posedge mclk_i);
      #1;
      for (n = 0; n < 60 && !ready_i; n++) begin
         waited = 1'b1;
         @(posedge mclk_i);
         #1;
      end
      rd = data_i;
      oe = oe_i;
      @(negedge mclk_i);
      host_o.cs_n = 1'b1;
      host_o.ds_n = 1'b1;
      host_o.data = ~host_o.data;
      repeat (3) @(posedge mclk_i);
      // Hand back off the sampling edge so callers never race the clock
      @(negedge mclk_i);
   endtask
endmodule // whp_host_model

// ---- verif/tb_whp_port.sv ----
// Self-checking bench of the wide host memory port
`timescale 1ns/1ps
module tb_whp_port;
   import whp_pkg::*;
   logic mclk_i, resetn_i, mux, psel, ctl_we, oe, w, hoe, host_wait_ready, hint, dint;
   logic [15:0] ctl_wd, rd, hd, dctl, d;
   logic [15:0] dv [3];
   logic [17:0] a;
   logic [31:0] seed = 32'h00011DE1;
   logic [15:0] mem [logic [17:0]];
   int n_errors = 0;
   int comparisons = 0;
   int dly = 0;
   whp_host_in_t host;
   whp_dma_req_t req;
   whp_dma_rsp_t rsp = '0;
   whp_port i_whp_port (.mclk_i(mclk_i), .resetn_i(resetn_i), .host_i(host),
      .addr_data_mux_select_i(mux), .wide_port_select_i(psel), .host_data_o(hd),
      .host_data_oe_o(hoe), .host_wait_ready_o(host_wait_ready), .host_int_o(hint), .dma_req_o(req),
      .dma_rsp_i(rsp), .dsp_ctl_we_i(ctl_we), .dsp_ctl_wdata_i(ctl_wd), .dsp_ctl_o(dctl),
      .dsp_int_o(dint));
   whp_host_model i_whp_host_model (.mclk_i(mclk_i), .ready_i(host_wait_ready), .oe_i(hoe),
      .data_i(hd), .host_o(host));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'hA3000000 : s >> 1;
   endfunction
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   // ----------------------------------------
   // DMA memory side, random latency
   // ----------------------------------------
   always @(negedge mclk_i) begin
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata;
      if (req.req && !rsp.ack) begin
         if (dly > 0) dly <= dly - 1;
         else begin
            chk1(req.prio, 1'b1);
            if (req.we) mem[req.addr] = req.wdata;
            rsp.rdata <= mem.exists(req.addr) ? mem[req.addr] : 16'h0;
            rsp.ack <= 1'b1;
            seed = lfsr(seed);
            dly <= seed[1:0];
         end
      end
   end
   task automatic chk1(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %0t flag %b exp %b", $time, g, e);
      end
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %0t word %h exp %h", $time, g, e);
      end
   endtask
   task automatic acc(input logic rw, input logic [1:0] sel, input logic [17:0] ad,
      input logic [15:0] wd);
      i_whp_host_model.xfer(rw, sel, ad, wd, rd, oe, w);
   endtask
   task automatic dsp(input logic [15:0] v);
      @(negedge mclk_i);
      ctl_we = 1'b1;
      ctl_wd = v;
      @(negedge mclk_i);
      ctl_we = 1'b0;
      repeat (2) @(negedge mclk_i);
   endtask
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Ample margin over roughly 300 cycles of traffic
   initial begin
      #100000;
      n_errors++;
      end_of_test;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      resetn_i = 1'b0;
      mux = 1'b0;
      psel = 1'b1;
      ctl_we = 1'b0;
      ctl_wd = 16'h0;
      repeat (3) @(negedge mclk_i);
      chk1(host_wait_ready & ~hoe & ~req.req & ~hint & ~dint, 1'b1);
      chk16(dctl, 16'h0);
      resetn_i = 1'b1;
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         a = (i == 0) ? 18'h3FFFF : seed[17:0];
         d = seed[31:16];
         acc(1'b0, 2'h3, a, d);
         chk1(w & ~oe, 1'b1);
         acc(1'b1, 2'h3, a, 16'h0);
         chk16(rd, d);
         chk1(oe, 1'b1);
      end
      acc(1'b0, 2'h0, 18'h00100, 16'h000F);
      chk16(mem[18'h00100], 16'h000F);
      chk16({dctl[15:1], dint}, 16'h0);
      $display("test separate done");
      mux = 1'b1;
      acc(1'b0, 2'h0, 18'h0, 16'h0004);
      chk16(dctl, 16'h0004);
      acc(1'b0, 2'h2, 18'h0, 16'h0002);
      acc(1'b0, 2'h0, 18'h0, 16'h0000);
      acc(1'b0, 2'h2, 18'h0, 16'hFFFE);
      for (int k = 0; k < 3; k++) begin
         seed = lfsr(seed);
         dv[k] = seed[15:0];
         acc(1'b0, 2'h1, 18'h0, dv[k]);
      end
      for (int k = 0; k < 3; k++) chk16(mem[18'h2FFFE + k], dv[k]);
      // Autoincrement carried into the upper bits, so reload both halves
      acc(1'b0, 2'h0, 18'h0, 16'h0004);
      acc(1'b0, 2'h2, 18'h0, 16'h0002);
      acc(1'b0, 2'h0, 18'h0, 16'h0000);
      acc(1'b0, 2'h2, 18'h0, 16'hFFFE);
      for (int k = 0; k < 3; k++) begin
         acc(1'b1, 2'h1, 18'h0, 16'h0);
         chk16(rd, dv[k]);
      end
      // Prefetch on: address write fetches, next data read needs no DMA
      acc(1'b0, 2'h0, 18'h0, 16'h0008);
      acc(1'b0, 2'h2, 18'h0, 16'h0000);
      chk1(w, 1'b1);
      acc(1'b1, 2'h1, 18'h0, 16'h0);
      chk16(rd, dv[2]);
      chk1(w, 1'b0);
      acc(1'b1, 2'h2, 18'h0, 16'h0);
      chk16(rd, 16'h0001);
      $display("test multiplexed done");
      acc(1'b0, 2'h0, 18'h0, 16'h0001);
      chk1(dint, 1'b1);
      dsp(16'h0001);
      chk1(dint, 1'b0);
      dsp(16'h0002);
      chk1(hint, 1'b1);
      acc(1'b1, 2'h0, 18'h0, 16'h0);
      chk16(rd, 16'h0002);
      acc(1'b0, 2'h0, 18'h0, 16'h0002);
      chk1(hint, 1'b0);
      $display("test interrupts done");
      end_of_test;
   end
endmodule // tb_whp_port
